// *** common/panel_regs.vh ***
`ifndef PANEL_REGS_VH
`define PANEL_REGS_VH
// Register offsets (word index on the plain register port)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_PARAM 4'h2
`define REG_SWEEP_POS 4'h3
`define REG_MARKER 4'h4
`define REG_DUTY 4'h5
`define REG_PHASE_INC 4'h6
`define REG_TRIG_INC 4'h7
// Control register fields
`define CTRL_LOCK_BIT 0
`define CTRL_REMOTE_BIT 1
`define CTRL_SHIFT_BIT 2
`define CTRL_EXTSRC_BIT 3
`define CTRL_SQUARE_BIT 4
`define CTRL_SWEEP_EN_BIT 5
// Reset values
`define PARAM_DEFAULT 32'h0000_03e8
`define DUTY_DEFAULT 32'h8000_0000
`define PHASE_INC_DEFAULT 32'h0000_1000
`define TRIG_INC_DEFAULT 32'h0000_0100
`define MARKER_DEFAULT 32'h8000_0000
// Sweep position step per clock while running and not held
`define SWEEP_STEP 32'h0000_0100
`define SLOT_COUNT 10
`endif

// *** verification/ext_gear_model.sv ***
`timescale 1ns/10ps
module ext_gear_model (
   input wire trig_run_i,
   input wire hold_i,
   input wire start_i,
   output reg ext_trig_o,
   output reg hold_n_o,
   output reg start_n_o
);
   // Pins rest high; timing is the far side's own, not the system clock
   initial begin
      ext_trig_o = 1'b1;
      hold_n_o = 1'b1;
      start_n_o = 1'b1;
   end
   always #37 ext_trig_o = trig_run_i ? ~ext_trig_o : 1'b1;
   always @(hold_i) hold_n_o <= #3 ~hold_i;
   always @(start_i) start_n_o <= #5 ~start_i;
endmodule

// *** verification/panel_io_checker.sv ***
`timescale 1ns/10ps
module panel_io_checker (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire main_waveform_output_o,
   input wire marker_crossing_output_o,
   input wire sweep_busy_n_o,
   input wire lock_flag_o,
   input wire edit_cursor_o,
   input wire name_blink_o,
   input wire output_off_flag_o,
   input wire remote_indicator_o,
   input wire one_shot_sweep_input_n_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // Start pin seen low well before the sweep flag drops
   sequence s_run_begins;
      $fell(sweep_busy_n_o);
   endsequence
   AST_LOCK_NO_CURSOR: assert property (lock_flag_o |-> !edit_cursor_o)
      else $error("cursor shown under lockout");
   AST_LOCK_NO_BLINK: assert property (lock_flag_o |-> !name_blink_o)
      else $error("name blinks under lockout");
   AST_REMOTE_NO_BLINK: assert property (remote_indicator_o |-> !name_blink_o)
      else $error("name blinks in remote");
   AST_REMOTE_HIDES_OFF: assert property (
      remote_indicator_o && $past(remote_indicator_o) |-> !output_off_flag_o)
      else $error("off flag shown in remote");
   AST_OFF_DISCONNECT: assert property (
      output_off_flag_o && $past(output_off_flag_o) |-> !main_waveform_output_o)
      else $error("main output live while off");
   AST_ON_AT_RESET: assert property ($rose(rstn_i) |-> !output_off_flag_o)
      else $error("output not on after reset");
   AST_MARKER_IN_SWEEP: assert property (!marker_crossing_output_o |-> !sweep_busy_n_o)
      else $error("marker low outside sweep");
   AST_START_EDGE: assert property (
      s_run_begins |-> !$past(one_shot_sweep_input_n_i, 3))
      else $error("sweep began without start edge");
endmodule

bind panel_setup_and_sweep_io panel_io_checker checker_i (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .main_waveform_output_o(main_waveform_output_o),
   .marker_crossing_output_o(marker_crossing_output_o), .sweep_busy_n_o(sweep_busy_n_o),
   .lock_flag_o(lock_flag_o), .edit_cursor_o(edit_cursor_o), .name_blink_o(name_blink_o),
   .output_off_flag_o(output_off_flag_o), .remote_indicator_o(remote_indicator_o),
   .one_shot_sweep_input_n_i(one_shot_sweep_input_n_i));

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`include "panel_regs.vh"
module testbench;
   reg clk_sys_i = 1'b0;
   reg rstn_i = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [3:0] digit = 4'h0;
   reg [31:0] wdata = 32'h0;
   reg [31:0] pent = 32'h0;
   reg [31:0] e;
   reg [31:0] m;
   reg [31:0] p;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg rd_q = 1'b0;
   reg dv = 1'b0;
   reg pen = 1'b0;
   reg trig_run = 1'b0;
   reg hold = 1'b0;
   reg start = 1'b0;
   reg [6:0] key = 7'h0;
   reg [31:0] slot [0:9];
   reg [31:0] exp_q [$];
   reg [31:0] msk_q [$];
   wire ext_trig, hold_n, start_n, busy_n, mark;
   wire [31:0] rdata;
   integer num_errors = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   always #4 clk_sys_i = ~clk_sys_i;
   ext_gear_model ext_gear_model_i (.trig_run_i(trig_run), .hold_i(hold), .start_i(start),
      .ext_trig_o(ext_trig), .hold_n_o(hold_n), .start_n_o(start_n));
   panel_setup_and_sweep_io panel_setup_and_sweep_io_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .setup_save_key_i(key[0]), .setup_restore_key_i(key[1]), .factory_defaults_key_i(key[2]),
      .summary_view_key_i(key[3]), .param_key_i(key[4]), .lock_key_i(key[5]),
      .output_key_i(key[6]), .digit_valid_i(dv), .digit_i(digit), .knob_step_i(dv),
      .param_entry_i(pent), .param_enter_i(pen), .external_trigger_input_i(ext_trig),
      .sweep_hold_n_i(hold_n), .one_shot_sweep_input_n_i(start_n),
      .main_waveform_output_o(), .sync_out_o(), .trigger_repeat_output_o(),
      .marker_crossing_output_o(mark), .sweep_busy_n_o(busy_n), .lock_flag_o(),
      .edit_cursor_o(), .name_blink_o(), .output_off_flag_o(), .remote_indicator_o(),
      .active_param_o());
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // One bus cycle; a read notes its expected word and mask
   task bus(input w, input [3:0] a, input [31:0] d, input [31:0] k);
      begin
         addr <= a;
         wdata <= d;
         wr <= w;
         rd <= !w;
         if (!w) exp_q.push_back(d);
         if (!w) msk_q.push_back(k);
         @(posedge clk_sys_i);
         wr <= 1'b0;
         rd <= 1'b0;
         // Let an edge pass so the next call never reassigns a strobe at once
         @(posedge clk_sys_i);
      end
   endtask
   // Key pulse, or digit pulse with a knob step beside it, then settle
   task act(input integer k, input [3:0] d, input [31:0] v);
      begin
         if (k < 7) key[k] <= 1'b1;
         dv <= (k == 7);
         pen <= (k == 8);
         digit <= d;
         pent <= v;
         @(posedge clk_sys_i);
         key <= 7'h0;
         dv <= 1'b0;
         pen <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
      end
   endtask
   // Read data stand only in the cycle after the strobe; hang guard too
   always @(posedge clk_sys_i) begin
      rd_q <= rd;
      cyc <= cyc + 1;
      if (rd_q) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         n_checks = n_checks + 1;
         if ((rdata & m) !== (e & m)) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h want %h", $time, rdata, e);
         end
      end
      if (cyc > 5000) begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end
   initial begin
      p = $urandom(32'hcb8e79c3);
      repeat (4) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(posedge clk_sys_i);
      bus(0, `REG_STATUS, 32'h9, 32'h9);
      bus(0, `REG_PARAM, `PARAM_DEFAULT, 32'hffff_ffff);
      bus(0, 4'h8 | $urandom % 8, 32'h0, 32'hffff_ffff);
      $display("reset values done");
      for (i = 0; i < 10; i = i + 1) begin
         slot[i] = $urandom;
         bus(1, `REG_PARAM, slot[i], 32'h0);
         act(0, 4'h0, 32'h0);
         act(7, i, 32'h0);
      end
      for (i = 9; i >= 0; i = i - 1) begin
         act(1, 4'h0, 32'h0);
         act(7, i, 32'h0);
         bus(0, `REG_PARAM, slot[i], 32'hffff_ffff);
      end
      act(1, 4'h0, 32'h0);
      act(7, 4'hb, 32'h0);
      act(7, 4'h5, 32'h0);
      bus(0, `REG_PARAM, slot[0], 32'hffff_ffff);
      bus(1, `REG_CTRL, 32'h4, 32'h0);
      act(2, 4'h0, 32'h0);
      bus(0, `REG_PARAM, `PARAM_DEFAULT, 32'hffff_ffff);
      $display("setup slots done");
      bus(1, `REG_CTRL, 32'h1, 32'h0);
      act(1, 4'h0, 32'h0);
      act(7, 4'h3, 32'h0);
      act(4, 4'h0, 32'h0);
      act(8, 4'h0, $urandom);
      act(6, 4'h0, 32'h0);
      bus(0, `REG_PARAM, `PARAM_DEFAULT, 32'hffff_ffff);
      bus(0, `REG_STATUS, 32'h0, 32'h1);
      act(5, 4'h0, 32'h0);
      bus(0, `REG_CTRL, 32'h0, 32'h1);
      bus(1, `REG_CTRL, 32'h2, 32'h0);
      act(4, 4'h0, 32'h0);
      act(8, 4'h0, $urandom);
      bus(0, `REG_PARAM, `PARAM_DEFAULT, 32'hffff_ffff);
      bus(1, `REG_CTRL, 32'h0, 32'h0);
      act(3, 4'h0, 32'h0);
      act(8, 4'h0, $urandom);
      bus(0, `REG_PARAM, `PARAM_DEFAULT, 32'hffff_ffff);
      p = $urandom;
      act(4, 4'h0, 32'h0);
      act(8, 4'h0, p);
      act(6, 4'h0, 32'h0);
      bus(0, `REG_PARAM, p, 32'hffff_ffff);
      bus(0, `REG_STATUS, 32'h1, 32'h1);
      $display("lockout and output key done");
      trig_run <= 1'b1;
      hold <= 1'b1;
      bus(1, `REG_MARKER, 32'h400, 32'h0);
      bus(1, `REG_CTRL, 32'h20, 32'h0);
      repeat (8) @(posedge clk_sys_i);
      start <= 1'b1;
      for (i = 0; i < 40 && busy_n !== 1'b0; i = i + 1) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      bus(0, `REG_STATUS, 32'h20, 32'h20);
      repeat (6) @(posedge clk_sys_i);
      bus(0, `REG_SWEEP_POS, 32'h0, 32'hffff_ffff);
      hold <= 1'b0;
      for (i = 0; i < 60 && mark !== 1'b0; i = i + 1) @(negedge clk_sys_i);
      n_checks = n_checks + 1;
      if (mark !== 1'b0) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: marker stayed high", $time);
      end
      @(posedge clk_sys_i);
      start <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      $display("sweep pins done");
      report_and_stop;
   end
endmodule

// *** verilog/panel_setup_and_sweep_io.v ***
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "panel_regs.vh"

// Summary of operation
// [RULE1] Ten setup slots, numbered 0 to 9, each holding a full parameter copy.
// [RULE2] Save mode plus a digit copies the active parameters into that slot.
// [RULE3] Restore mode plus a digit loads that slot into the active parameters.
// [RULE4] Only digit keys pick a slot; knob steps are ignored then.
// [RULE5] Lockout is one for on; it blocks key programming and mode changes.
// [RULE6] Lockout spares lock, summary and output keys, trigger and sweep inputs.
// [RULE7] Under lockout show lock flag, no blink, no edit cursor.
// [RULE8] Shifted defaults key loads the factory parameter set.
// [RULE9] Summary view forbids edits until a parameter key is chosen.
// [RULE10] Each output key press inverts the main output enable.
// [RULE11] Output off disconnects main waveform; sync square keeps running.
// [RULE12] Output-off flag shown unless in shifted or remote mode.
// [RULE13] Output enable comes up on after reset.
// [RULE14] Sync output is a square at main frequency; duty follows setting in square.
// [RULE15] External trigger input reads high when idle, keeping a gate open.
// [RULE16] Trigger output repeats external input or internal oscillator by source.
// [RULE17] Sweep freezes while the hold input is low, resumes when high.
// [RULE18] Single sweep starts on a falling edge of the one-shot input.
// [RULE19] Marker output low while swept frequency exceeds marker, else high.
// [RULE20] Sweep-in-progress output low while a sweep runs, else high.
// [RULE21] Under remote control panel parameter setting is refused.
// [RULE22] Trigger, hold and one-shot inputs are synchronised before use.
module panel_setup_and_sweep_io #(
   parameter PW = 32
) (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire ce_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire setup_save_key_i,
   input wire setup_restore_key_i,
   input wire factory_defaults_key_i,
   input wire summary_view_key_i,
   input wire param_key_i,
   input wire lock_key_i,
   input wire output_key_i,
   input wire digit_valid_i,
   input wire [3:0] digit_i,
   input wire knob_step_i,
   input wire [PW-1:0] param_entry_i,
   input wire param_enter_i,
   input wire external_trigger_input_i,
   input wire sweep_hold_n_i,
   input wire one_shot_sweep_input_n_i,
   output reg main_waveform_output_o,
   output reg sync_out_o,
   output reg trigger_repeat_output_o,
   output reg marker_crossing_output_o,
   output reg sweep_busy_n_o,
   output reg lock_flag_o,
   output reg edit_cursor_o,
   output reg name_blink_o,
   output reg output_off_flag_o,
   output reg remote_indicator_o,
   output reg [PW-1:0] active_param_o
);

   // Register map on the plain port (word index):
   //   0 control: lock, remote, shift, external source, square, sweep enable
   //   1 status: output enable, save mode, restore mode, summary, hold, sweep run
   //   2 active parameter word
   //   3 sweep position, read only
   //   4 marker point, 5 duty threshold
   //   6 waveform phase step, 7 trigger oscillator phase step
   // Unmapped offsets read as zero and ignore writes.

   // Reset and factory value of the active parameter word, cut to PW bits below
   localparam [31:0] PARAM_DEF = `PARAM_DEFAULT;

   // [RULE1] ten setup slots
   // One word per slot, indexed by the decimal digit; digits above nine never
   // reach the array, so the four-bit index cannot run past the last entry.
   reg [PW-1:0] slot_mem [0:`SLOT_COUNT-1];
   reg [PW-1:0] param_r;
   reg [31:0] ctrl_r;
   reg [31:0] marker_r;
   reg [31:0] duty_r;
   reg [31:0] phase_inc_r;
   reg [31:0] trig_inc_r;
   reg [31:0] phase_r;
   reg [31:0] trig_phase_r;
   reg [31:0] sweep_pos_r;
   reg out_en_r;
   reg save_mode_r;
   reg restore_mode_r;
   reg summary_r;
   reg sweep_run_r;

   // Pin levels after the synchronisers: bit 0 trigger, 1 hold, 2 start
   wire [2:0] pin_raw_w;
   wire [2:0] pin_s_w;
   wire trig_s_w;
   wire hold_s_w;
   wire start_s_w;
   reg start_prev_r;

   wire lock_w = ctrl_r[`CTRL_LOCK_BIT];
   wire remote_w = ctrl_r[`CTRL_REMOTE_BIT];
   wire shift_w = ctrl_r[`CTRL_SHIFT_BIT];
   wire ext_src_w = ctrl_r[`CTRL_EXTSRC_BIT];
   wire square_w = ctrl_r[`CTRL_SQUARE_BIT];
   wire sweep_en_w = ctrl_r[`CTRL_SWEEP_EN_BIT];

   // Keys that program the unit; blocked by lockout or remote control.
   // The summary and output keys bypass this gate on purpose; the lock key is blocked by remote control only.
   wire keys_ok_w = ~lock_w & ~remote_w;
   // Digits above nine are treated as no slot at all
   wire digit_ok_w = digit_valid_i & (digit_i < 4'd10);
   // Edge taken from the filtered level, so one pin bounce gives one start
   wire start_fall_w = start_prev_r & ~start_s_w;
   // [RULE4] knob ignored
   // The knob step input is left unread: slot choice uses digits only,
   // so a turn of the knob can neither pick a slot nor cancel a pending one.

   // Pins in one vector so the synchroniser below is written once
   assign pin_raw_w = {one_shot_sweep_input_n_i, sweep_hold_n_i, external_trigger_input_i};
   assign trig_s_w = pin_s_w[0];
   assign hold_s_w = pin_s_w[1];
   assign start_s_w = pin_s_w[2];

   // [RULE22] synchronise pin inputs
   // Three stage flops and one level flop per pin; a level counts once stages two and three agree,
   // so a glitch shorter than a clock never reaches the sweep or trigger logic.
   // Reset to high, the idle level of every pin, so no false edge follows reset.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : pin_sync
         reg [2:0] stage_r;
         reg level_r;
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               stage_r <= 3'h7;
               level_r <= 1'b1;
            end else if (ce_i) begin
               stage_r <= {stage_r[1:0], pin_raw_w[g]};
               if (stage_r[1] == stage_r[2]) begin
                  level_r <= stage_r[2];
               end
            end
         end
         assign pin_s_w[g] = level_r;
      end
   endgenerate

   // Previous start level for the falling-edge detector; idles high
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_prev_r <= 1'b1;
      end else if (ce_i) begin
         start_prev_r <= start_s_w;
      end
   end

   // Slot writes; memory has no reset so it maps to plain RAM.
   // A slot read before its first store returns unknown contents; software
   // that needs a clean recall stores every slot once after power-up.
   always @(posedge clk_sys_i) begin
      // [RULE2] digit stores setup
      if (ce_i && save_mode_r && digit_ok_w && keys_ok_w) begin
         slot_mem[digit_i] <= param_r;
      end
   end

   // Panel key handling and active parameter set.
   // A register write to CTRL or PARAM wins over a key in the same cycle, so
   // remote software always sees its own value land.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         param_r <= PARAM_DEF[PW-1:0];
         // [RULE13] output on at reset
         out_en_r <= 1'b1;
         save_mode_r <= 1'b0;
         restore_mode_r <= 1'b0;
         summary_r <= 1'b1;
         ctrl_r <= 32'h0000_0000;
      end else if (ce_i) begin
         if (wr_i && addr_i == `REG_CTRL) begin
            ctrl_r <= wdata_i;
         end else if (lock_key_i && !remote_w) begin
            // [RULE6] lock key still acts
            ctrl_r[`CTRL_LOCK_BIT] <= ~lock_w;
         end
         // [RULE10] toggle output enable
         if (output_key_i) begin
            out_en_r <= ~out_en_r;
         end
         // [RULE9] summary view blocks edits
         if (summary_view_key_i) begin
            summary_r <= 1'b1;
         end else if (param_key_i && keys_ok_w) begin
            summary_r <= 1'b0;
         end
         // [RULE5] modes refused under lockout
         // Save and restore exclude each other; the later key wins, and
         // any digit afterwards closes the pending choice.
         if (setup_save_key_i && keys_ok_w) begin
            save_mode_r <= 1'b1;
            restore_mode_r <= 1'b0;
         end else if (setup_restore_key_i && keys_ok_w) begin
            restore_mode_r <= 1'b1;
            save_mode_r <= 1'b0;
         end else if (digit_valid_i) begin
            // [RULE4] only digits close slot choice
            save_mode_r <= 1'b0;
            restore_mode_r <= 1'b0;
         end
         // Only one source updates the active word per cycle: bus first,
         // then defaults, then recall, then a typed entry.
         if (wr_i && addr_i == `REG_PARAM) begin
            param_r <= wdata_i[PW-1:0];
         end else if (keys_ok_w) begin
            // [RULE8] shifted defaults key
            if (factory_defaults_key_i && shift_w) begin
               param_r <= PARAM_DEF[PW-1:0];
            // [RULE3] digit recalls setup
            end else if (restore_mode_r && digit_ok_w) begin
               param_r <= slot_mem[digit_i];
            // [RULE21] edits refused in remote
            end else if (param_enter_i && !summary_r) begin
               param_r <= param_entry_i;
            end
         end
      end
   end

   // Tuning registers reached over the register port.
   // Writes to other offsets leave all four untouched.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         marker_r <= `MARKER_DEFAULT;
         duty_r <= `DUTY_DEFAULT;
         phase_inc_r <= `PHASE_INC_DEFAULT;
         trig_inc_r <= `TRIG_INC_DEFAULT;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            `REG_MARKER: marker_r <= wdata_i;
            `REG_DUTY: duty_r <= wdata_i;
            `REG_PHASE_INC: phase_inc_r <= wdata_i;
            `REG_TRIG_INC: trig_inc_r <= wdata_i;
            default: marker_r <= marker_r;
         endcase
      end
   end

   // Phase accumulators for the waveform and internal trigger oscillator.
   // Both run even with the main output off, so the sync pin never stops.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_r <= 32'h0000_0000;
         trig_phase_r <= 32'h0000_0000;
      end else if (ce_i) begin
         phase_r <= phase_r + phase_inc_r;
         trig_phase_r <= trig_phase_r + trig_inc_r;
      end
   end

   // Sweep engine.
   // The position stops one step short of wrapping and then ends the run;
   // a new start edge is only taken once the previous run has ended.
   // Clearing the enable bit aborts a run at once and parks the position.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sweep_run_r <= 1'b0;
         sweep_pos_r <= 32'h0000_0000;
      end else if (ce_i) begin
         if (!sweep_en_w) begin
            sweep_run_r <= 1'b0;
            sweep_pos_r <= 32'h0000_0000;
         // [RULE18] start on falling edge
         end else if (start_fall_w && !sweep_run_r) begin
            sweep_run_r <= 1'b1;
            sweep_pos_r <= 32'h0000_0000;
         // [RULE17] hold freezes sweep
         end else if (sweep_run_r && hold_s_w) begin
            if (sweep_pos_r > 32'hffff_ffff - `SWEEP_STEP) begin
               sweep_run_r <= 1'b0;
            end else begin
               sweep_pos_r <= sweep_pos_r + `SWEEP_STEP;
            end
         end
      end
   end

   // Output pins and indicators, all registered.
   // Registering keeps glitches off the pins; each indicator therefore
   // trails its cause by one clock.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         main_waveform_output_o <= 1'b0;
         sync_out_o <= 1'b0;
         trigger_repeat_output_o <= 1'b1;
         marker_crossing_output_o <= 1'b1;
         sweep_busy_n_o <= 1'b1;
         lock_flag_o <= 1'b0;
         edit_cursor_o <= 1'b0;
         name_blink_o <= 1'b0;
         output_off_flag_o <= 1'b0;
         remote_indicator_o <= 1'b0;
         active_param_o <= PARAM_DEF[PW-1:0];
      end else if (ce_i) begin
         // [RULE14] sync square, duty in square mode
         // Outside square mode the phase MSB gives a fixed half duty
         sync_out_o <= square_w ? (phase_r < duty_r) : ~phase_r[31];
         // [RULE11] gate main path only
         main_waveform_output_o <= out_en_r &
            (square_w ? (phase_r < duty_r) : ~phase_r[31]);
         // [RULE16] trigger source routing
         // [RULE15] idle input reads high
         // Internal oscillator is the phase MSB, a square at the trigger rate
         trigger_repeat_output_o <= ext_src_w ? trig_s_w : ~trig_phase_r[31];
         // [RULE19] marker low above marker point
         // Compared only while a run is active, so the pin rests high between runs
         marker_crossing_output_o <= ~(sweep_run_r && sweep_pos_r > marker_r);
         // [RULE20] busy low while sweeping
         sweep_busy_n_o <= ~sweep_run_r;
         // [RULE7] lock indicator, no cursor
         lock_flag_o <= lock_w;
         edit_cursor_o <= keys_ok_w & ~summary_r;
         name_blink_o <= keys_ok_w & ~summary_r;
         // [RULE12] off flag except shift/remote
         output_off_flag_o <= ~out_en_r & ~shift_w & ~remote_w;
         remote_indicator_o <= remote_w;
         active_param_o <= param_r;
      end
   end

   // Read port, data one cycle after the strobe; unmapped reads zero.
   // The data word falls back to zero in the next cycle, so a master must
   // take it in the single cycle after its strobe.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         rdata_o <= 32'h0000_0000;
         if (rd_i) begin
            case (addr_i)
               `REG_CTRL: rdata_o <= ctrl_r;
               `REG_STATUS: rdata_o <= {26'h0, sweep_run_r, hold_s_w,
                  summary_r, restore_mode_r, save_mode_r, out_en_r};
               `REG_PARAM: rdata_o <= param_r;
               `REG_SWEEP_POS: rdata_o <= sweep_pos_r;
               `REG_MARKER: rdata_o <= marker_r;
               `REG_DUTY: rdata_o <= duty_r;
               `REG_PHASE_INC: rdata_o <= phase_inc_r;
               `REG_TRIG_INC: rdata_o <= trig_inc_r;
               default: rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule
